// >>> msi_consts.vh
// register map, field positions and reset values of the motion sensor interface
`ifndef MSI_CONSTS_VH
`define MSI_CONSTS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define MSI_ADDR_W 4
`define MSI_OFF_CTRL 4'h0
`define MSI_OFF_STAT 4'h1
`define MSI_OFF_MASK 4'h2
`define MSI_OFF_TRIM 4'h3

// ----------------------------------------
// field positions
// ----------------------------------------
`define MSI_CTRL_MEN 3
`define MSI_CTRL_SEL_HI 2
`define MSI_CTRL_SEL_LO 1
`define MSI_CTRL_START 0
`define MSI_STAT_MOTION 1
`define MSI_STAT_FLAG 0
`define MSI_MASK_MIE 0

// ----------------------------------------
// stage select codes and reset values
// ----------------------------------------
`define MSI_SEL_OFF 2'h0
`define MSI_SEL_CAP 2'h1
`define MSI_SEL_VOLT 2'h3
`define MSI_RST_TRIM 8'h00
`define MSI_RST_CTRL 4'h0

// ----------------------------------------
// measurement timing: settle time and clock period in ns, settle count in reference clock cycles
// ----------------------------------------
`define MSI_SETTLE_NS 200
`define MSI_CLK_NS 20
`define MSI_SETTLE_CYC ((`MSI_SETTLE_NS + `MSI_CLK_NS - 1) / `MSI_CLK_NS)

`endif

// >>> msi_motion_sensor.v
// motion sensor interface: control registers, poll sequencer, status and event flag
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "msi_consts.vh"

module msi_motion_sensor (
  input wire ref_clk,                     // 50 MHz system clock
  input wire resetn,                      // asynchronous reset, active low
  input wire [`MSI_ADDR_W-1:0] reg_addr,  // register address
  input wire [7:0] reg_wdata,             // write data
  input wire reg_wr,                      // write strobe
  input wire reg_rd,                      // read strobe
  output reg [7:0] reg_rdata,             // read data, cycle after strobe
  input wire cap_freq_in,                 // capacitance unit frequency (pin domain)
  input wire volt_freq_in,                // voltage unit frequency (pin domain)
  input wire motion_poll_clock,           // low-power poll clock from timer0
  input wire cmp_below_ref,               // comparator: pin voltage below reference
  input wire global_irq_en,               // core global interrupt enable
  input wire irq_vector_ack,              // pulse: motion vector being executed
  output reg sensor_freq_out,             // selected frequency to timer2 clock
  output reg sensor_pin_ground,           // force all sensor pins to ground
  output reg sensor_pin_oe_n,             // sensor pin drive enable, low drives
  output reg ref_switch_on,               // closes divider switch during sampling
  output reg cmp_enable,                  // powers the comparator stage
  output reg [7:0] ref_trim_value,        // trim to reference generator
  output reg cap_unit_en,                 // capacitance unit enable
  output reg volt_unit_en,                // voltage unit enable
  output reg meas_start,                  // measurement start level
  output reg sensor_irq_line              // motion interrupt request
);

  // ----------------------------------------
  // sequencer states
  // ----------------------------------------
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_SETTLE = 4'b0010;
  localparam [3:0] ST_SAMPLE = 4'b0100;
  localparam [3:0] ST_DONE = 4'b1000;
  // settle count is worked out in cycles from ns by the header; the counter holds eight bits
  localparam integer SETTLE_INT = `MSI_SETTLE_CYC;
  localparam [7:0] SETTLE_CYC = SETTLE_INT[7:0];

  // ----------------------------------------
  // synchronised inputs
  // ----------------------------------------
  // every pin-side input is async to ref_clk, so each one gets two flops
  wire cap_freq_s;
  wire volt_freq_s;
  wire poll_s;
  wire motion_compare_out;

  msi_sync2 u_sync_cap (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .d_in(cap_freq_in),
    .q_out(cap_freq_s)
  );

  msi_sync2 u_sync_volt (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .d_in(volt_freq_in),
    .q_out(volt_freq_s)
  );

  msi_sync2 u_sync_poll (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .d_in(motion_poll_clock),
    .q_out(poll_s)
  );

  msi_sync2 u_sync_cmp (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .d_in(cmp_below_ref),
    .q_out(motion_compare_out)
  );

  // ----------------------------------------
  // register state
  // ----------------------------------------
  reg motion_unit_enable_q;
  reg [1:0] sensor_stage_select_q;
  reg meas_start_q;
  reg [7:0] trim_q;
  reg motion_irq_enable_q;
  reg motion_status_bit_q;
  reg motion_event_flag_q;
  reg motion_event_flag_d;
  reg poll_prev_q;
  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [7:0] cnt_q;
  reg [7:0] cnt_d;
  reg [7:0] rdata_d;

  wire wr_ctrl = reg_wr && (reg_addr == `MSI_OFF_CTRL);
  wire wr_stat = reg_wr && (reg_addr == `MSI_OFF_STAT);
  wire wr_mask = reg_wr && (reg_addr == `MSI_OFF_MASK);
  wire wr_trim = reg_wr && (reg_addr == `MSI_OFF_TRIM);
  wire cap_on = (sensor_stage_select_q == `MSI_SEL_CAP);
  wire volt_on = (sensor_stage_select_q == `MSI_SEL_VOLT);
  // detector resets low like the idle poll clock, so reset gives no false start
  wire poll_rise = poll_s && !poll_prev_q;
  // cap unit grounding the pins makes any sample meaningless
  wire sample_ok = motion_unit_enable_q && !cap_on;

  // ----------------------------------------
  // writable control registers
  // ----------------------------------------
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      motion_unit_enable_q <= 1'b0;
      sensor_stage_select_q <= `MSI_SEL_OFF;
      meas_start_q <= 1'b0;
      trim_q <= `MSI_RST_TRIM;
      motion_irq_enable_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        motion_unit_enable_q <= reg_wdata[`MSI_CTRL_MEN];
        sensor_stage_select_q <= reg_wdata[`MSI_CTRL_SEL_HI:`MSI_CTRL_SEL_LO];
        meas_start_q <= reg_wdata[`MSI_CTRL_START];
      end
      if (wr_trim) begin
        trim_q <= reg_wdata;
      end
      if (wr_mask) begin
        motion_irq_enable_q <= reg_wdata[`MSI_MASK_MIE];
      end
    end
  end

  // ----------------------------------------
  // poll sequencer, restarted from idle by disabling the unit
  // ----------------------------------------
  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      ST_IDLE: begin
        if (sample_ok && poll_rise) begin
          state_d = ST_SETTLE;
          cnt_d = SETTLE_CYC;
        end
      end
      ST_SETTLE: begin
        // divider and comparator need the full settle time before a sample counts
        if (cnt_q <= 8'h01) begin
          state_d = ST_SAMPLE;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      ST_SAMPLE: begin
        state_d = ST_DONE;
      end
      ST_DONE: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (!sample_ok) begin
      state_d = ST_IDLE;
      cnt_d = 8'h00;
    end
  end

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      cnt_q <= 8'h00;
      poll_prev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      poll_prev_q <= poll_s;
    end
  end

  // ----------------------------------------
  // motion status and event flag
  // ----------------------------------------
  always @* begin
    motion_event_flag_d = motion_event_flag_q;
    if (irq_vector_ack || (wr_stat && reg_wdata[`MSI_STAT_FLAG])) begin
      motion_event_flag_d = 1'b0;
    end
    // rising edge sets, wins over clear
    if ((state_q == ST_SAMPLE) && motion_compare_out && !motion_status_bit_q) begin
      motion_event_flag_d = 1'b1;
    end
  end

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      motion_status_bit_q <= 1'b0;
      motion_event_flag_q <= 1'b0;
    end else begin
      motion_event_flag_q <= motion_event_flag_d;
      if (!sample_ok) begin
        motion_status_bit_q <= 1'b0;
      end else if (state_q == ST_SAMPLE) begin
        motion_status_bit_q <= motion_compare_out;
      end
    end
  end

  // ----------------------------------------
  // read mux, answered the cycle after the strobe
  // ----------------------------------------
  always @* begin
    rdata_d = 8'h00;
    case (reg_addr)
      `MSI_OFF_CTRL: begin
        rdata_d = {4'h0, motion_unit_enable_q, sensor_stage_select_q, meas_start_q};
      end
      `MSI_OFF_STAT: begin
        rdata_d = {6'h00, motion_status_bit_q, motion_event_flag_q};
      end
      `MSI_OFF_MASK: begin
        rdata_d = {7'h00, motion_irq_enable_q};
      end
      `MSI_OFF_TRIM: begin
        rdata_d = trim_q;
      end
      default: begin
        rdata_d = 8'h00;
      end
    endcase
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
      sensor_freq_out <= 1'b0;
      sensor_pin_ground <= 1'b0;
      sensor_pin_oe_n <= 1'b1;
      ref_switch_on <= 1'b0;
      cmp_enable <= 1'b0;
      ref_trim_value <= `MSI_RST_TRIM;
      cap_unit_en <= 1'b0;
      volt_unit_en <= 1'b0;
      meas_start <= 1'b0;
      sensor_irq_line <= 1'b0;
    end else begin
      // read data is zero outside the answer cycle, so stale values never linger
      reg_rdata <= reg_rd ? rdata_d : 8'h00;
      sensor_freq_out <= cap_on ? cap_freq_s : (volt_on ? volt_freq_s : 1'b0);
      sensor_pin_ground <= cap_on;
      sensor_pin_oe_n <= !cap_on;
      // switch closes one cycle late, the price of a registered output
      ref_switch_on <= (state_q == ST_SETTLE) || (state_q == ST_SAMPLE);
      cmp_enable <= sample_ok;
      ref_trim_value <= trim_q;
      cap_unit_en <= cap_on;
      volt_unit_en <= volt_on;
      meas_start <= meas_start_q && (cap_on || volt_on);
      sensor_irq_line <= motion_event_flag_d && motion_irq_enable_q && global_irq_en;
    end
  end

endmodule

`default_nettype wire

// >>> msi_motion_sensor_chk.sv
// port assertions of the motion sensor interface
`timescale 1ns/100ps
`default_nettype none
`include "msi_consts.vh"
module msi_motion_sensor_chk (
  input wire logic ref_clk, // clock
  input wire logic resetn, // reset, low
  input wire logic [3:0] reg_addr, // address
  input wire logic [7:0] reg_wdata, // wdata
  input wire logic reg_wr, // write
  input wire logic reg_rd, // read
  input wire logic [7:0] reg_rdata, // rdata
  input wire logic global_irq_en, // gie
  input wire logic irq_vector_ack, // vector
  input wire logic cap_freq_in, // cap freq pin
  input wire logic volt_freq_in, // volt freq pin
  input wire logic sensor_freq_out, // freq
  input wire logic sensor_pin_ground, // ground
  input wire logic sensor_pin_oe_n, // drive, low
  input wire logic ref_switch_on, // switch
  input wire logic cmp_enable, // comparator
  input wire logic [7:0] ref_trim_value, // trim
  input wire logic cap_unit_en, // cap
  input wire logic volt_unit_en, // volt
  input wire logic meas_start, // start
  input wire logic sensor_irq_line // irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // ------------------------------
  // sampling window: settle plus sample
  // ------------------------------
  sequence s_arm;
    $rose(ref_switch_on);
  endsequence
  sequence s_hold;
    ref_switch_on[*8] ##1 ref_switch_on[*3] ##1 !ref_switch_on;
  endsequence
  a_sample_window: assert property (s_arm |-> s_hold)
    else $error("switch window length wrong");
  a_freq_off: assert property (!cap_unit_en && !volt_unit_en |-> !sensor_freq_out)
    else $error("frequency out while no stage");
  // two sync flops plus the output flop: the pin shows up three edges later
  a_freq_cap: assert property (cap_unit_en |-> sensor_freq_out == $past(cap_freq_in, 3))
    else $error("cap frequency not routed");
  a_freq_volt: assert property (volt_unit_en |-> sensor_freq_out == $past(volt_freq_in, 3))
    else $error("volt frequency not routed");
  a_start_gate: assert property (meas_start |-> cap_unit_en || volt_unit_en)
    else $error("start without stage");
  a_cap_ground: assert property (cap_unit_en |-> sensor_pin_ground && !sensor_pin_oe_n && !cmp_enable)
    else $error("cap stage not grounding pins");
  a_irq_gate: assert property (sensor_irq_line |-> $past(global_irq_en))
    else $error("irq without global enable");
  a_ack_clear: assert property (irq_vector_ack && !ref_switch_on |=> !sensor_irq_line)
    else $error("irq kept after vector");
  // trim output is a registered copy of the trim register, one edge behind it
  a_trim_write: assert property (reg_wr && reg_addr == `MSI_OFF_TRIM |=> ##1 ref_trim_value == $past(reg_wdata, 2))
    else $error("trim not written");
  a_trim_hold: assert property (!(reg_wr && reg_addr == `MSI_OFF_TRIM) |=> ##1 $stable(ref_trim_value))
    else $error("trim changed unasked");
  a_mask_rsvd: assert property (reg_rd && reg_addr == `MSI_OFF_MASK |=> reg_rdata[7:1] == 7'h00)
    else $error("mask reserved bits set");
endmodule
bind msi_motion_sensor msi_motion_sensor_chk i_chk (.ref_clk(ref_clk), .resetn(resetn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .global_irq_en(global_irq_en), .irq_vector_ack(irq_vector_ack),
  .cap_freq_in(cap_freq_in), .volt_freq_in(volt_freq_in),
  .sensor_freq_out(sensor_freq_out), .sensor_pin_ground(sensor_pin_ground),
  .sensor_pin_oe_n(sensor_pin_oe_n), .ref_switch_on(ref_switch_on), .cmp_enable(cmp_enable),
  .ref_trim_value(ref_trim_value), .cap_unit_en(cap_unit_en), .volt_unit_en(volt_unit_en),
  .meas_start(meas_start), .sensor_irq_line(sensor_irq_line));
`default_nettype wire

// >>> msi_sensor_model.sv
// behavioural model of the external capacitive motion sensor on its pin
`timescale 1ns/100ps
`default_nettype none
module msi_sensor_model (
  input wire logic ref_clk, // system clock
  input wire logic sw_on, // divider switch closed
  input wire logic gnd, // pins forced to ground
  input wire logic motion, // sensor is being moved
  output var logic cmp // comparator: pin below reference
);
  logic junk_q;
  // outside sampling the comparator output is meaningless, so it churns
  always @(posedge ref_clk) begin
    junk_q <= ~junk_q;
  end
  always @* begin
    cmp = (sw_on && !gnd) ? motion : junk_q;
  end
  initial junk_q = 1'b0;
endmodule
`default_nettype wire

// >>> msi_sync2.v
// two-stage synchroniser for one asynchronous level
`timescale 1ns/100ps
`default_nettype none

module msi_sync2 (
  input wire ref_clk,  // system clock
  input wire resetn,   // asynchronous reset, active low
  input wire d_in,     // asynchronous level
  output reg q_out     // synchronised level
);

  reg meta_q;

  // ----------------------------------------
  // first stage only feeds the second
  // ----------------------------------------
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= 1'b0;
      q_out <= 1'b0;
    end else begin
      meta_q <= d_in;
      q_out <= meta_q;
    end
  end

endmodule

`default_nettype wire

// >>> tb.sv
// self-checking bench of the motion sensor interface
`timescale 1ns/100ps
`default_nettype none
`include "msi_consts.vh"
module tb;
  reg ref_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, cap_f = 1'b0;
  reg volt_f = 1'b0, poll = 1'b0, gie = 1'b0, ack = 1'b0, mot = 1'b0;
  reg [3:0] reg_addr = 4'h0;
  reg [7:0] reg_wdata = 8'h00, v;
  reg [31:0] seed = 32'h0000bf92;
  wire [7:0] rdata, trim;
  wire cmp, fo, gnd, oe_n, sw, cmp_en, cap_en, volt_en, start, irq;
  integer err_count = 0, compares = 0, cyc = 0, i;
  always #10 ref_clk = ~ref_clk;
  msi_motion_sensor i_msi_motion_sensor (.ref_clk(ref_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(rdata), .cap_freq_in(cap_f), .volt_freq_in(volt_f), .motion_poll_clock(poll),
    .cmp_below_ref(cmp), .global_irq_en(gie), .irq_vector_ack(ack), .sensor_freq_out(fo),
    .sensor_pin_ground(gnd), .sensor_pin_oe_n(oe_n), .ref_switch_on(sw), .cmp_enable(cmp_en),
    .ref_trim_value(trim), .cap_unit_en(cap_en), .volt_unit_en(volt_en), .meas_start(start),
    .sensor_irq_line(irq));
  msi_sensor_model i_msi_sensor_model (.ref_clk(ref_clk), .sw_on(sw), .gnd(gnd),
    .motion(mot), .cmp(cmp));
  // ------------------------------
  // random source, unit frequencies and hang guard
  // ------------------------------
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  always @(posedge ref_clk) begin
    seed <= xs(seed);
    cap_f <= seed[3];
    volt_f <= seed[7];
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count = err_count + 1;
      conclude;
    end
  end
  // ------------------------------
  // bus tasks; spare edges let registered outputs settle before any check
  // ------------------------------
  task chk(input [8*6-1:0] nm, input [7:0] e, input [7:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("Error %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      repeat (2) @(posedge ref_clk);
    end
  endtask
  task rd(input [3:0] a, input [7:0] e);
    begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk("rdata", e, rdata);
      @(posedge ref_clk);
    end
  endtask
  // one poll clock period; a measurement takes 13 cycles after sync
  task pl(input m);
    begin
      mot <= m;
      poll <= 1'b1;
      repeat (4) @(posedge ref_clk);
      poll <= 1'b0;
      repeat (16) @(posedge ref_clk);
    end
  endtask
  task conclude;
    begin
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    rd(`MSI_OFF_TRIM, 8'h00);
    rd(`MSI_OFF_MASK, 8'h00);
    for (i = 0; i < 8; i = i + 1) begin
      v = (i == 0) ? 8'hff : seed[7:0];
      wr(`MSI_OFF_TRIM, v);
      chk("trim", v, trim);
      rd(`MSI_OFF_TRIM, v);
      rd(4'h4 + {1'b0, seed[10:8]}, 8'h00);
    end
    for (i = 0; i < 4; i = i + 1) begin
      wr(`MSI_OFF_CTRL, {5'h00, i[1:0], 1'b1});
      chk("cap", {7'h00, i == 1}, {7'h00, cap_en});
      chk("volt", {7'h00, i == 3}, {7'h00, volt_en});
      chk("ground", {7'h00, i == 1}, {7'h00, gnd});
      chk("start", {7'h00, (i == 1) || (i == 3)}, {7'h00, start});
    end
    gie <= 1'b1;
    wr(`MSI_OFF_MASK, 8'hff);
    rd(`MSI_OFF_MASK, 8'h01);
    // sleep mode choice stays with core software, outside this block
    // poll clock is set up and quiet before the unit is enabled
    wr(`MSI_OFF_CTRL, 8'h08);
    pl(1'b1);
    chk("irq", 8'h01, {7'h00, irq});
    rd(`MSI_OFF_STAT, 8'h03);
    ack <= 1'b1;
    @(posedge ref_clk);
    ack <= 1'b0;
    @(posedge ref_clk);
    chk("irq", 8'h00, {7'h00, irq});
    wr(`MSI_OFF_STAT, 8'h00);
    rd(`MSI_OFF_STAT, 8'h02);
    pl(1'b1);
    rd(`MSI_OFF_STAT, 8'h02);
    pl(1'b0);
    rd(`MSI_OFF_STAT, 8'h00);
    wr(`MSI_OFF_MASK, 8'h00);
    pl(1'b1);
    chk("irq", 8'h00, {7'h00, irq});
    rd(`MSI_OFF_STAT, 8'h03);
    gie <= 1'b0;
    wr(`MSI_OFF_MASK, 8'h01);
    chk("irq", 8'h00, {7'h00, irq});
    gie <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk("irq", 8'h01, {7'h00, irq});
    wr(`MSI_OFF_STAT, 8'h01);
    rd(`MSI_OFF_STAT, 8'h02);
    wr(`MSI_OFF_CTRL, 8'h00);
    pl(1'b1);
    rd(`MSI_OFF_STAT, 8'h00);
    wr(`MSI_OFF_CTRL, 8'h0a);
    pl(1'b1);
    rd(`MSI_OFF_STAT, 8'h00);
    conclude;
  end
endmodule
`default_nettype wire
